// ==== sram_port.sv ====
`timescale 1ns/1ps
`include "sram_port_defines.svh"

module sram_port
  import sram_port_pkg::*;
(
  input wire logic mclk, // Clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic organisation, // Strap: 0 wide, 1 narrow.
  input wire logic clock_qualify_n, // Clock qualifier, active low.
  input wire logic [`ADDR_W-1:0] address, // Word address.
  input wire logic chip_select_one_n, // Chip select, active low.
  input wire logic chip_select_two, // Chip select, active high.
  input wire logic chip_select_three_n, // Chip select, active low.
  input wire logic write_n, // Write strobe, active low.
  input wire logic [`LANES-1:0] byte_lane_write_n, // Byte lane write selects.
  input wire logic advance_or_load, // High advances burst, low loads.
  input wire logic burst_interleave, // Burst order select.
  input wire logic output_enable_n, // Output enable, active low, sampled each clock.
  input wire logic sleep_request, // Sleep request, from a pin.
  input wire logic [`DATA_W-1:0] dq_in, // Data bus seen from pins.
  output logic [`DATA_W-1:0] dq_out, // Read data to pins.
  output logic [`DATA_W-1:0] dq_oe, // Per-bit output enable.
  output logic low_power // Low-power state indicator.
);

  // ==========================================================================
  // Pin synchroniser for sleep
  // ==========================================================================
  logic [2:0] sleep_sync_reg;
  logic [2:0] sleep_sync_next;
  logic sleep_level_reg;
  logic sleep_level_next;

  always_comb begin
    sleep_sync_next = {sleep_sync_reg[1:0], sleep_request};
    sleep_level_next = sleep_level_reg;
    if (sleep_sync_reg[1] == sleep_sync_reg[2]) begin
      sleep_level_next = sleep_sync_reg[2];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_sync_reg <= 3'h0;
      sleep_level_reg <= 1'b0;
    end else begin
      sleep_sync_reg <= sleep_sync_next;
      sleep_level_reg <= sleep_level_next;
    end
  end

  // ==========================================================================
  // Input registers
  // ==========================================================================
  logic qual_n_reg;
  logic [`ADDR_W-1:0] addr_reg;
  logic [`ADDR_W-1:0] addr_next;
  logic sel_reg;
  logic sel_next;
  logic wr_reg;
  logic wr_next;
  logic [`LANES-1:0] lanes_reg;
  logic [`LANES-1:0] lanes_next;
  logic adv_reg;
  logic adv_next;
  logic ilv_reg;
  logic ilv_next;
  logic org_reg;
  logic org_next;
  logic org_taken_reg;
  logic org_taken_next;
  logic [`DATA_W-1:0] wdata_reg;
  logic [`DATA_W-1:0] wdata_next;
  logic hold;

  // Combined select: all three must be active at the edge.
  function automatic logic selected(input logic s1_n, input logic s2, input logic s3_n);
    selected = !s1_n && s2 && !s3_n;
  endfunction : selected

  assign hold = qual_n_reg;

  always_comb begin
    addr_next = addr_reg;
    sel_next = sel_reg;
    wr_next = wr_reg;
    lanes_next = lanes_reg;
    adv_next = adv_reg;
    ilv_next = ilv_reg;
    wdata_next = wdata_reg;
    org_next = org_reg;
    org_taken_next = 1'b1;
    // The strap is caught once, on the first clock after reset release.
    if (!org_taken_reg) begin
      org_next = organisation;
    end
    if (!clock_qualify_n) begin
      addr_next = address;
      sel_next = selected(chip_select_one_n, chip_select_two, chip_select_three_n);
      wr_next = !write_n;
      lanes_next = ~byte_lane_write_n;
      adv_next = advance_or_load;
      ilv_next = burst_interleave;
    end
    if (!hold) begin
      wdata_next = dq_in;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      qual_n_reg <= 1'b1;
      addr_reg <= '0;
      sel_reg <= 1'b0;
      wr_reg <= 1'b0;
      lanes_reg <= '0;
      adv_reg <= 1'b0;
      ilv_reg <= 1'b0;
      org_reg <= `ORG_WIDE;
      org_taken_reg <= 1'b0;
      wdata_reg <= '0;
    end else begin
      qual_n_reg <= clock_qualify_n;
      addr_reg <= addr_next;
      sel_reg <= sel_next;
      wr_reg <= wr_next;
      lanes_reg <= lanes_next;
      adv_reg <= adv_next;
      ilv_reg <= ilv_next;
      org_reg <= org_next;
      org_taken_reg <= org_taken_next;
      wdata_reg <= wdata_next;
    end
  end

  // ==========================================================================
  // Operation decode and burst address
  // ==========================================================================
  op_t op_reg;
  op_t op_next;
  logic [`ADDR_W-1:0] base_reg;
  logic [`ADDR_W-1:0] base_next;
  logic [`BURST_W-1:0] burst_off;
  logic new_cycle;
  logic burst_step;
  logic burst_load;
  logic [`ADDR_W-1:0] eff_addr;

  // A new command is held in the input registers for exactly one
  // qualified cycle; a stalled cycle repeats nothing.
  assign new_cycle = !hold;
  assign burst_load = new_cycle && sel_reg && !adv_reg;
  assign burst_step = new_cycle && adv_reg && (op_reg != op_idle);

  burst_counter u_burst (
    .mclk(mclk),
    .arst_n(arst_n),
    .step(burst_step),
    .load(burst_load),
    .start(addr_reg[`BURST_W-1:0]),
    .interleave(ilv_reg),
    .offset(burst_off)
  );

  always_comb begin
    op_next = op_reg;
    base_next = base_reg;
    if (new_cycle) begin
      if (!adv_reg) begin
        base_next = addr_reg;
        op_next = !sel_reg ? op_idle : (wr_reg ? op_write : op_read);
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      op_reg <= op_idle;
      base_reg <= '0;
    end else begin
      op_reg <= op_next;
      base_reg <= base_next;
    end
  end

  // On a load the address comes straight from the input register, so the
  // command is decoded in the cycle after capture.
  logic [`BURST_W-1:0] cur_off;
  logic [`ADDR_W-1:0] cur_base;
  op_t cur_op;
  assign cur_off = burst_load ? addr_reg[`BURST_W-1:0] : burst_off;
  assign cur_base = burst_load ? addr_reg : base_reg;
  assign cur_op = !new_cycle ? op_idle : (!adv_reg ? (!sel_reg ? op_idle :
                  (wr_reg ? op_write : op_read)) : op_reg);
  assign eff_addr = {cur_base[`ADDR_W-1:`BURST_W], cur_off};

  // ==========================================================================
  // Access stage
  // ==========================================================================
  // Write data arrives one edge after its command, so the array access is
  // staged by one edge; a read right behind a write then sees the new word.
  logic [`ADDR_W-1:0] acc_addr_reg;
  logic [`ADDR_W-1:0] acc_addr_next;
  logic [`LANES-1:0] acc_lanes_reg;
  logic [`LANES-1:0] acc_lanes_next;
  op_t acc_op_reg;
  op_t acc_op_next;
  logic acc_hold_reg;
  logic acc_hold_next;

  always_comb begin
    acc_addr_next = eff_addr;
    acc_lanes_next = lanes_reg;
    acc_op_next = cur_op;
    acc_hold_next = hold;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      acc_addr_reg <= '0;
      acc_lanes_reg <= '0;
      acc_op_reg <= op_idle;
      acc_hold_reg <= 1'b0;
    end else begin
      acc_addr_reg <= acc_addr_next;
      acc_lanes_reg <= acc_lanes_next;
      acc_op_reg <= acc_op_next;
      acc_hold_reg <= acc_hold_next;
    end
  end

  // ==========================================================================
  // Array access with lane mapping
  // ==========================================================================
  logic [`ADDR_W-1:0] word_addr;
  logic [`LANES-1:0] lane_en;
  logic [`DATA_W-1:0] arr_wdata;
  logic [`DATA_W-1:0] arr_rdata;
  logic [`DATA_W-1:0] rdata_mapped;
  logic array_wr;

  // Narrow mode: the low address bit picks the half of a wide word, and the
  // two lanes are mirrored to that half.
  always_comb begin
    word_addr = acc_addr_reg;
    lane_en = acc_lanes_reg;
    arr_wdata = wdata_reg;
    rdata_mapped = arr_rdata;
    if (org_reg == `ORG_NARROW) begin
      word_addr = {1'b0, acc_addr_reg[`ADDR_W-1:1]};
      arr_wdata = {wdata_reg[2*`LANE_W-1:0], wdata_reg[2*`LANE_W-1:0]};
      lane_en = acc_addr_reg[0] ? {acc_lanes_reg[1:0], 2'h0} :
                {2'h0, acc_lanes_reg[1:0]};
      rdata_mapped = {{(2*`LANE_W){1'b0}}, acc_addr_reg[0] ?
                      arr_rdata[`DATA_W-1:2*`LANE_W] : arr_rdata[2*`LANE_W-1:0]};
    end else begin
      word_addr = {1'b0, acc_addr_reg[`ADDR_W-2:0]};
    end
  end

  assign array_wr = (acc_op_reg == op_write) && !sleep_level_reg;

  sram_array u_array (
    .mclk(mclk),
    .wr(array_wr),
    .waddr(word_addr),
    .lane_en(lane_en),
    .wdata(arr_wdata),
    .raddr(word_addr),
    .rdata(arr_rdata)
  );

  // ==========================================================================
  // Output drivers and power state
  // ==========================================================================
  logic [`DATA_W-1:0] dq_out_next;
  logic [`DATA_W-1:0] dq_oe_next;
  logic drive;
  power_t pw_reg;
  power_t pw_next;
  logic low_power_next;

  // Output enable is sampled each clock here; the pad wrapper must also gate
  // the buffer with it directly for true asynchronous float.
  assign drive = (acc_op_reg == op_read) && !output_enable_n && (pw_reg != pw_sleep);

  always_comb begin
    dq_out_next = dq_out;
    dq_oe_next = '0;
    if (drive) begin
      dq_out_next = rdata_mapped;
      dq_oe_next = (org_reg == `ORG_NARROW) ? {{(2*`LANE_W){1'b0}},
                    {(2*`LANE_W){1'b1}}} : {`DATA_W{1'b1}};
    end else if (acc_hold_reg && !output_enable_n) begin
      dq_oe_next = dq_oe;
    end
    pw_next = pw_reg;
    case (pw_reg)
      pw_active: begin
        if (sleep_level_reg) pw_next = pw_sleep;
        else if (!hold && !sel_reg && (cur_op == op_idle)) pw_next = pw_standby;
      end
      pw_standby: begin
        if (sleep_level_reg) pw_next = pw_sleep;
        else if (cur_op != op_idle) pw_next = pw_active;
      end
      pw_sleep: begin
        if (!sleep_level_reg) pw_next = pw_active;
      end
      default: pw_next = pw_active;
    endcase
    low_power_next = (pw_next != pw_active);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dq_out <= '0;
      dq_oe <= '0;
      pw_reg <= pw_active;
      low_power <= 1'b0;
    end else begin
      dq_out <= dq_out_next;
      dq_oe <= dq_oe_next;
      pw_reg <= pw_next;
      low_power <= low_power_next;
    end
  end

endmodule : sram_port

// ==== sram_port_defines.svh ====
`ifndef SRAM_PORT_DEFINES_SVH
`define SRAM_PORT_DEFINES_SVH

// Organisation: 0 selects 256K x 36, 1 selects 512K x 18.
`define ORG_WIDE 1'b0
`define ORG_NARROW 1'b1
`define ADDR_W 19
`define DATA_W 36
`define LANES 4
`define LANE_W 9
`define WIDE_DEPTH 262144
`define NARROW_DEPTH 524288
`define BURST_W 2
`define SLEEP_ENTRY_CYCLES 2

`endif

// ==== sram_port_pkg.sv ====
package sram_port_pkg;

  typedef enum logic [1:0] {
    op_idle,
    op_read,
    op_write
  } op_t;

  typedef enum {
    pw_active,
    pw_standby,
    pw_sleep
  } power_t;

endpackage : sram_port_pkg

// ==== burst_counter.sv ====
`timescale 1ns/1ps
`include "sram_port_defines.svh"

module burst_counter
  import sram_port_pkg::*;
(
  input wire logic mclk, // Clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic step, // Advance this cycle.
  input wire logic load, // Load a new start offset.
  input wire logic [`BURST_W-1:0] start, // Start offset.
  input wire logic interleave, // Interleaved order when high.
  output logic [`BURST_W-1:0] offset // Current burst offset.
);

  logic [`BURST_W-1:0] base_reg;
  logic [`BURST_W-1:0] base_next;
  logic [`BURST_W-1:0] count_reg;
  logic [`BURST_W-1:0] count_next;

  always_comb begin
    base_next = base_reg;
    count_next = count_reg;
    if (load) begin
      base_next = start;
      // The load cycle itself uses the start offset, so the next beat is one.
      count_next = 2'h1;
    end else if (step) begin
      count_next = count_reg + 2'h1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      base_reg <= 2'h0;
      count_reg <= 2'h0;
    end else begin
      base_reg <= base_next;
      count_reg <= count_next;
    end
  end

  // Interleaved order flips bits of the start; linear wraps within four.
  assign offset = interleave ? (base_reg ^ count_reg) : (base_reg + count_reg);

endmodule : burst_counter

// ==== sram_array.sv ====
`timescale 1ns/1ps
`include "sram_port_defines.svh"

module sram_array
  import sram_port_pkg::*;
(
  input wire logic mclk, // Clock.
  input wire logic wr, // Write this cycle.
  input wire logic [`ADDR_W-1:0] waddr, // Write word address.
  input wire logic [`LANES-1:0] lane_en, // Lanes to update.
  input wire logic [`DATA_W-1:0] wdata, // Write data.
  input wire logic [`ADDR_W-1:0] raddr, // Read word address.
  output logic [`DATA_W-1:0] rdata // Read data, combinational.
);

  // Narrow words live in half lanes of the wide array, so one array serves both.
  logic [`LANE_W-1:0] mem [0:`NARROW_DEPTH-1][0:`LANES-1];

  genvar g;
  generate
    for (g = 0; g < `LANES; g++) begin : lane
      always_ff @(posedge mclk) begin
        if (wr && lane_en[g]) begin
          mem[waddr][g] <= wdata[g*`LANE_W +: `LANE_W];
        end
      end
      assign rdata[g*`LANE_W +: `LANE_W] = mem[raddr][g];
    end
  endgenerate

endmodule : sram_array

// ==== sram_port_asserts.sv ====
`timescale 1ns/1ps
`include "sram_port_defines.svh"
// ============================================================
// Port timing checks.
module sram_port_asserts (
  input wire logic mclk, // Clock.
  input wire logic arst_n, // Reset, active low.
  input wire logic clock_qualify_n, // Edge qualifier.
  input wire logic chip_select_one_n, // Select, low.
  input wire logic chip_select_two, // Select, high.
  input wire logic chip_select_three_n, // Select, low.
  input wire logic write_n, // Write strobe.
  input wire logic advance_or_load, // Burst advance.
  input wire logic output_enable_n, // Output enable.
  input wire logic sleep_request, // Sleep pin.
  input wire logic [`DATA_W-1:0] dq_out, // Read data.
  input wire logic [`DATA_W-1:0] dq_oe, // Drive enables.
  input wire logic low_power // Power state.
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  wire sel = !chip_select_one_n && chip_select_two && !chip_select_three_n;
  wire go = !clock_qualify_n && !output_enable_n && !sleep_request;
  wire rd_ld = go && sel && write_n && !advance_or_load;
  wire wr_ld = !clock_qualify_n && sel && !write_n && !advance_or_load;
  wire ds_ld = !clock_qualify_n && !sel && !advance_or_load;
  // Each command owns the output slot after its third qualified edge.
  property p_rd_drive;
    (!sleep_request)[*4] ##0 rd_ld ##1 go[*2] |=> &dq_oe[17:0];
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read beat not driven");
  property p_burst;
    (!sleep_request)[*4] ##0 rd_ld ##1 (go && advance_or_load)[*3] ##1 go |=> &dq_oe[17:0];
  endproperty
  a_burst: assert property (p_burst) else $error("burst beat not driven");
  property p_wr_float;
    wr_ld ##1 (!clock_qualify_n)[*2] |=> dq_oe == '0;
  endproperty
  a_wr_float: assert property (p_wr_float) else $error("driving in write slot");
  property p_ds_float;
    ds_ld ##1 (!clock_qualify_n)[*2] |=> dq_oe == '0;
  endproperty
  a_ds_float: assert property (p_ds_float) else $error("driving while deselected");
  property p_oe_off;
    output_enable_n && !clock_qualify_n |=> dq_oe == '0;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("drive with enable off");
  property p_stall;
    clock_qualify_n[*2] ##0 !output_enable_n |=> $stable(dq_out) && $stable(dq_oe);
  endproperty
  a_stall: assert property (p_stall) else $error("outputs moved in stall");
  property p_sleep_pw;
    $rose(sleep_request) ##1 sleep_request[*7] |=> low_power;
  endproperty
  a_sleep_pw: assert property (p_sleep_pw) else $error("sleep not entered");
  property p_sleep_quiet;
    sleep_request[*8] |=> dq_oe == '0;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("driving in sleep");
endmodule : sram_port_asserts

bind sram_port sram_port_asserts u_chk (.mclk, .arst_n, .clock_qualify_n,
  .chip_select_one_n, .chip_select_two, .chip_select_three_n, .write_n,
  .advance_or_load, .output_enable_n, .sleep_request, .dq_out, .dq_oe, .low_power);

// ==== sram_host.sv ====
`timescale 1ns/1ps
`include "sram_port_defines.svh"
// ============================================================
// Host controller model: one command per falling edge.
module sram_host (
  input wire logic mclk, // Clock.
  output logic clock_qualify_n, // Edge qualifier.
  output logic [`ADDR_W-1:0] address, // Word address.
  output logic chip_select_one_n, // Select, low.
  output logic chip_select_two, // Select, high.
  output logic chip_select_three_n, // Select, low.
  output logic write_n, // Write strobe.
  output logic [`LANES-1:0] byte_lane_write_n, // Lane selects.
  output logic advance_or_load, // Burst advance.
  output logic [`DATA_W-1:0] dq_in // Write data.
);
  logic wr_pend = 1'b0;
  logic [`DATA_W-1:0] d_pend = '0;
  initial begin
    clock_qualify_n = 1'b0;
    {chip_select_three_n, chip_select_two, chip_select_one_n} = 3'b011;
    write_n = 1'b1;
    advance_or_load = 1'b0;
    address = '0;
    byte_lane_write_n = '1;
    dq_in = '0;
  end
  // A free data bus toggles every qualified cycle, so stale data can never pass for fresh.
  task automatic cycle(input logic q_n, input logic [2:0] cs, input logic wr,
                       input logic adv, input logic [`ADDR_W-1:0] a,
                       input logic [`LANES-1:0] be_n, input logic [`DATA_W-1:0] d);
    @(negedge mclk);
    if (!clock_qualify_n) begin
      dq_in = wr_pend ? d_pend : ~dq_in;
      wr_pend = 1'b0;
    end
    clock_qualify_n = q_n;
    if (!q_n) begin
      {chip_select_three_n, chip_select_two, chip_select_one_n} = cs;
      write_n = ~wr;
      advance_or_load = adv;
      address = a;
      byte_lane_write_n = be_n;
      wr_pend = wr;
      d_pend = d;
    end
  endtask : cycle
endmodule : sram_host

// ==== flow_through_sync_sram_port_tb_top.sv ====
`timescale 1ns/1ps
`include "sram_port_defines.svh"
module flow_through_sync_sram_port_tb_top;
  localparam logic [35:0] W = '1;
  localparam logic [35:0] N = 36'h3ffff;
  localparam logic [35:0] X1 = 36'h123456789;
  localparam logic [35:0] X3 = 36'h0a5a5a5a5;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic organisation = 1'b0;
  logic output_enable_n = 1'b0;
  logic burst_interleave = 1'b0;
  logic sleep_request = 1'b0;
  logic clock_qualify_n, chip_select_one_n, chip_select_two, chip_select_three_n;
  logic write_n, advance_or_load, low_power;
  logic [`ADDR_W-1:0] address;
  logic [`LANES-1:0] byte_lane_write_n;
  logic [`DATA_W-1:0] dq_in, dq_out, dq_oe;
  int n_mismatch = 0;
  int cmp_count = 0;
  always #2.5 mclk = ~mclk;
  sram_host u_host (.mclk, .clock_qualify_n, .address, .chip_select_one_n, .chip_select_two,
    .chip_select_three_n, .write_n, .byte_lane_write_n, .advance_or_load, .dq_in);
  sram_port u_dut (.mclk, .arst_n, .organisation, .clock_qualify_n, .address,
    .chip_select_one_n, .chip_select_two, .chip_select_three_n, .write_n,
    .byte_lane_write_n, .advance_or_load, .burst_interleave, .output_enable_n,
    .sleep_request, .dq_in, .dq_out, .dq_oe, .low_power);
  // ============================================================
  // Helpers.
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic see(input logic [35:0] d, input logic [35:0] m);
    chk(dq_oe & m, m);
    chk(dq_out & m, d & m);
  endtask : see
  task automatic op(input logic w, input logic [18:0] a, input logic [3:0] b,
                    input logic [35:0] d);
    u_host.cycle(1'b0, 3'b010, w, 1'b0, a, b, d);
  endtask : op
  task automatic nop;
    u_host.cycle(1'b0, 3'b011, 1'b0, 1'b0, '0, '0, '0);
  endtask : nop
  task automatic do_reset;
    @(negedge mclk);
    arst_n = 1'b0;
    repeat (20) @(negedge mclk);
    chk(dq_out | dq_oe, '0);
    arst_n = 1'b1;
    nop;
    nop;
  endtask : do_reset
  // ============================================================
  // Scenarios. A read issued k calls back is seen after call k plus three.
  task automatic s_mix;
    op(1'b1, 19'h1, 4'h0, X1);
    op(1'b1, 19'h1, 4'h5, W);
    nop;
    op(1'b0, 19'h1, 4'h0, '0);
    op(1'b1, 19'h2, 4'h0, X3);
    op(1'b0, 19'h1, 4'h0, '0);
    op(1'b0, 19'h2, 4'h0, '0);
    see(X1 | 36'hff803fe00, W);
    nop;
    chk(dq_oe, '0);
    nop;
    see(X1 | 36'hff803fe00, W);
    nop;
    see(X3, W);
  endtask : s_mix
  task automatic s_stall;
    op(1'b1, 19'h3, 4'h0, 36'h0c3c3c3c3);
    u_host.cycle(1'b1, 3'b010, 1'b0, 1'b0, '0, '0, '0);
    u_host.cycle(1'b1, 3'b010, 1'b0, 1'b0, '0, '0, '0);
    op(1'b0, 19'h3, 4'h0, '0);
    repeat (3) nop;
    see(36'h0c3c3c3c3, W);
  endtask : s_stall
  task automatic s_oe;
    op(1'b0, 19'h2, 4'h0, '0);
    nop;
    output_enable_n = 1'b1;
    nop;
    nop;
    chk(dq_oe, '0);
    output_enable_n = 1'b0;
  endtask : s_oe
  task automatic s_sel;
    logic [2:0] cs [3] = '{3'b011, 3'b000, 3'b110};
    for (int k = 0; k < 3; k++) begin
      u_host.cycle(1'b0, cs[k], 1'b1, 1'b0, 19'h2, 4'h0, '0);
      u_host.cycle(1'b0, cs[k], 1'b0, 1'b0, 19'h2, 4'h0, '0);
      op(1'b0, 19'h2, 4'h0, '0);
      nop;
      chk(dq_oe, '0);
      nop;
      chk(dq_oe, '0);
      nop;
      see(X3, W);
    end
    chk({35'h0, low_power}, 36'h1);
  endtask : s_sel
  task automatic s_burst;
    logic [1:0] o;
    for (int i = 0; i < 4; i++) u_host.cycle(1'b0, 3'b010, 1'b1, i > 0, 19'h8, 4'h0, 36'h100 + i);
    for (int m = 0; m < 2; m++) begin
      burst_interleave = m[0];
      for (int i = 0; i < 7; i++) begin
        if (i < 4) u_host.cycle(1'b0, 3'b010, 1'b0, i > 0, 19'h9, 4'h0, '0);
        else nop;
        o = m[0] ? 2'd1 ^ 2'(i - 3) : 2'd1 + 2'(i - 3);
        if (i >= 3) see({34'h40, o}, W);
      end
    end
  endtask : s_burst
  task automatic s_sleep;
    sleep_request = 1'b1;
    repeat (10) nop;
    chk({35'h0, low_power}, 36'h1);
    op(1'b1, 19'h2, 4'h0, '0);
    op(1'b0, 19'h2, 4'h0, '0);
    nop;
    nop;
    nop;
    chk(dq_oe, '0);
    sleep_request = 1'b0;
    repeat (10) nop;
    op(1'b0, 19'h2, 4'h0, '0);
    repeat (3) nop;
    see(X3, W);
  endtask : s_sleep
  task automatic s_narrow;
    organisation = 1'b1;
    do_reset;
    op(1'b1, 19'h7ffff, 4'h0, N);
    op(1'b1, 19'h7ffff, 4'he, '0);
    op(1'b1, 19'h7fffe, 4'h0, 36'h12345);
    op(1'b0, 19'h7ffff, 4'h0, '0);
    op(1'b0, 19'h7fffe, 4'h0, '0);
    nop;
    nop;
    see(36'h3fe00, N);
    nop;
    see(36'h12345, N);
  endtask : s_narrow
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  initial begin
    do_reset;
    s_mix;
    s_stall;
    s_oe;
    s_sel;
    s_burst;
    s_sleep;
    s_narrow;
    summarize;
  end
  // About four thousand cycles; the whole run needs far fewer.
  initial begin
    #20000;
    n_mismatch++;
    summarize;
  end
endmodule : flow_through_sync_sram_port_tb_top
